/* File: common/pld_pkg.sv */
// Package for the output cell array: register map, fields, reset values, modes.
// Assumes one 100 MHz clock and a classic Wishbone slave with a 10-bit byte address.
package pld_pkg;
    localparam int N_CELLS = 8;
    localparam int N_DED = 7;
    localparam int N_IN = 15;
    localparam int N_LIT = 30;
    localparam int TERMS_PER_CELL = 8;
    localparam int N_TERMS = 64;
    localparam int ADR_W = 10;
    localparam logic [9:0] ADR_MODE = 10'h000;
    localparam logic [9:0] ADR_POL = 10'h004;
    localparam logic [9:0] ADR_IOSEL = 10'h008;
    localparam logic [9:0] ADR_SIG_LO = 10'h00C;
    localparam logic [9:0] ADR_SIG_HI = 10'h010;
    localparam logic [9:0] ADR_DIS_LO = 10'h014;
    localparam logic [9:0] ADR_DIS_HI = 10'h018;
    localparam logic [9:0] ADR_PRELOAD = 10'h01C;
    localparam logic [9:0] ADR_STATUS = 10'h020;
    localparam logic [1:0] ROW_PAGE = 2'h1;
    localparam int MODE_SYNC_BIT = 0;
    localparam int MODE_ARCH_BIT = 1;
    localparam int STATUS_PD_BIT = 0;
    localparam int STATUS_MODE_LSB = 1;
    localparam logic [29:0] RST_ROW = 30'h3FFFFFFF;
    localparam logic [1:0] RST_MODE = 2'h1;
    localparam logic [7:0] RST_POL = 8'h00;
    localparam logic [7:0] RST_IOSEL = 8'h00;
    localparam logic [63:0] RST_SIG = 64'h0000000000000000;
    localparam logic [63:0] RST_DIS = 64'h0000000000000000;
    localparam logic [7:0] RST_CELL_Q = 8'h00;

    typedef enum logic [1:0] {
        MODE_SIMPLE = 2'h0,
        MODE_COMPLEX = 2'h1,
        MODE_REGISTERED = 2'h3
    } mode_e;

    typedef struct packed {
        logic [1:0] mode_bits;
        logic [7:0] pol;
        logic [7:0] io_sel;
        logic [63:0] sig;
        logic [63:0] dis;
    } cfg_s;

    function automatic mode_e mode_decode(input logic [1:0] bits);
        if (!bits[MODE_SYNC_BIT])
            return MODE_REGISTERED;
        else if (bits[MODE_ARCH_BIT])
            return MODE_COMPLEX;
        else
            return MODE_SIMPLE;
    endfunction
endpackage

/* File: design/term_array.sv */
// Product-term array: 64 AND terms over 15 inputs in true and complement form.
// Assumes inputs are already routed; the power-down pin never reaches here.
module term_array (
    // Array inputs and fuse rows
    input wire logic [14:0] in_i,
    input wire logic [63:0][29:0] rows_i,
    input wire logic [63:0] dis_i,
    // Product terms
    output logic [63:0] terms_o
);
    logic [29:0] lit;

    genvar i;
    generate
        for (i = 0; i < pld_pkg::N_IN; i++)
        begin : g_lit
            assign lit[2*i] = in_i[i];
            assign lit[2*i+1] = ~in_i[i];
        end
        for (i = 0; i < pld_pkg::N_TERMS; i++)
        begin : g_term
            // A set row bit connects the literal; a disabled term drops out
            assign terms_o[i] = ~dis_i[i] & (&(lit | ~rows_i[i]));
        end
    endgenerate
endmodule

/* File: design/output_cell.sv */
// One output cell: mode-dependent sum, polarity, output enable and register.
// Assumes its eight product terms come from the shared array, term 0 first.
module output_cell #(
    parameter bit INNER = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration
    input wire pld_pkg::mode_e mode_i,
    input wire logic pol_i,
    input wire logic io_sel_i,
    // Logic inputs
    input wire logic [7:0] terms_i,
    input wire logic tick_i,
    input wire logic oe_n_i,
    input wire logic preload_i,
    input wire logic preload_val_i,
    // Cell results
    output logic q_o,
    output logic drive_o,
    output logic oe_o
);
    typedef struct packed {
        logic q;
    } cell_s;

    cell_s s_q, s_d;
    logic sum8, sum7;

    assign sum8 = |terms_i;
    assign sum7 = |terms_i[7:1];
    assign q_o = s_q.q;

    always_comb
    begin
        s_d = s_q;
        drive_o = 1'b0;
        oe_o = 1'b0;
        case (mode_i)
            pld_pkg::MODE_REGISTERED:
            begin
                if (!io_sel_i)
                begin
                    drive_o = s_q.q;
                    oe_o = ~oe_n_i;
                end
                else
                begin
                    drive_o = sum7 ^ pol_i;
                    oe_o = terms_i[0];
                end
            end
            pld_pkg::MODE_COMPLEX:
            begin
                drive_o = sum7 ^ pol_i;
                oe_o = terms_i[0];
            end
            default:
            begin
                // Inner cells cannot become inputs here
                drive_o = sum8 ^ pol_i;
                oe_o = ~(io_sel_i & ~INNER);
            end
        endcase
        if (preload_i)
            s_d.q = preload_val_i;
        else if (tick_i && mode_i == pld_pkg::MODE_REGISTERED && !io_sel_i)
            s_d.q = sum8 ^ pol_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    a_reg_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_i && !preload_i && mode_i == pld_pkg::MODE_REGISTERED && !io_sel_i)
        |=> q_o == $past(sum8 ^ pol_i))
        else $error("registered cell missed its capture");
endmodule

/* File: design/pld_core.sv */
// Top of the output cell array with its Wishbone configuration slave.
// Assumes pin inputs are synchronous to clk_i; the board resolves tri-state wires.
//
// Summary of operation
// - Two global bits select simple, complex or registered mode for all cells.
// - Each cell has a polarity bit and an input/output select bit.
// - Registered mode uses pin one as clock, pin two as enable, never data.
// - All registered cells share the one clock pin and one enable pin.
// - Registered mode lets each cell be registered or combinational input/output.
// - Registered cells sum eight terms; combinational cells sum seven, except in simple mode, where they sum eight.
// - Complex mode feeds the two dedicated pins via the outer cell feedback.
// - Complex mode: seven data terms plus one enable term per cell.
// - Outside registered mode both dedicated pins are array data inputs.
// - Simple mode cells are inputs or always-enabled outputs.
// - Simple mode outputs sum up to eight terms with selectable polarity.
// - Simple mode feedback uses adjacent pins; inner cells are outputs only.
// - Power-down pin never feeds the array and puts the device in standby.
// - The array takes fifteen inputs from dedicated pins and feedback.
// - Registers clear at reset and can be preloaded for testing.
// - Store holds signature bits and per-term disable bits.
// - Registers capture their term sum on a rising clock pin edge.
module pld_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Dedicated pins
    input wire logic clk_pin_i,
    input wire logic oe_pin_n_i,
    input wire logic [6:0] in_i,
    input wire logic power_down_i,
    // Cell pins
    input wire logic [7:0] cell_pin_i,
    output logic [7:0] cell_pin_o,
    output logic [7:0] cell_pin_oe_o,
    output logic standby_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        pld_pkg::cfg_s cfg;
        logic [63:0][29:0] rows;
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
        logic clkp;
        logic standby;
    } top_s;

    top_s s_q, s_d;
    pld_pkg::mode_e mode;
    logic req, wr, tick, preload;
    logic [7:0] fb, cell_q, cell_drive, cell_oe, pt_oe;
    logic [14:0] arr_in;
    logic [63:0] terms;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    function automatic logic is_row(input logic [9:0] adr);
        return adr[9:8] == pld_pkg::ROW_PAGE;
    endfunction

    assign mode = pld_pkg::mode_decode(s_q.cfg.mode_bits);
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr = req & wb_we_i;
    assign preload = wr && wb_adr_i == pld_pkg::ADR_PRELOAD;
    // Pins are synchronous, so the previous sample is enough for an edge
    assign tick = clk_pin_i & ~s_q.clkp & ~power_down_i;

    // Feedback columns per mode
    always_comb
    begin
        fb = '0;
        for (int k = 0; k < pld_pkg::N_CELLS; k++)
        begin
            if (mode == pld_pkg::MODE_REGISTERED)
                fb[k] = s_q.cfg.io_sel[k] ? cell_pin_i[k] : cell_q[k];
            else if (k == 0)
                fb[k] = oe_pin_n_i;
            else if (k == pld_pkg::N_CELLS - 1)
                fb[k] = clk_pin_i;
            else if (mode == pld_pkg::MODE_COMPLEX)
                fb[k] = cell_pin_i[k];
            else if (k < 4)
                fb[k] = cell_pin_i[k-1];
            else
                fb[k] = cell_pin_i[k+1];
        end
    end

    // Power-down pin is deliberately absent from the array inputs
    assign arr_in = {fb, in_i};

    term_array u_array (
        .in_i(arr_in),
        .rows_i(s_q.rows),
        .dis_i(s_q.cfg.dis),
        .terms_o(terms)
    );

    genvar k;
    generate
        for (k = 0; k < pld_pkg::N_CELLS; k++)
        begin : g_cell
            assign pt_oe[k] = terms[pld_pkg::TERMS_PER_CELL*k];
            output_cell #(
                .INNER(k == 3 || k == 4)
            ) u_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .mode_i(mode),
                .pol_i(s_q.cfg.pol[k]),
                .io_sel_i(s_q.cfg.io_sel[k]),
                .terms_i(terms[pld_pkg::TERMS_PER_CELL*k +: pld_pkg::TERMS_PER_CELL]),
                .tick_i(tick),
                .oe_n_i(oe_pin_n_i),
                .preload_i(preload),
                .preload_val_i(wb_dat_i[k]),
                .q_o(cell_q[k]),
                .drive_o(cell_drive[k]),
                .oe_o(cell_oe[k])
            );
        end
    endgenerate

    always_comb
    begin
        logic [31:0] rd;
        logic [31:0] w;
        rd = 32'h00000000;
        w = 32'h00000000;
        s_d = s_q;
        if (is_row(wb_adr_i))
            rd = {2'h0, s_q.rows[wb_adr_i[7:2]]};
        else
        begin
            case (wb_adr_i)
                pld_pkg::ADR_MODE: rd = {30'h00000000, s_q.cfg.mode_bits};
                pld_pkg::ADR_POL: rd = {24'h000000, s_q.cfg.pol};
                pld_pkg::ADR_IOSEL: rd = {24'h000000, s_q.cfg.io_sel};
                pld_pkg::ADR_SIG_LO: rd = s_q.cfg.sig[31:0];
                pld_pkg::ADR_SIG_HI: rd = s_q.cfg.sig[63:32];
                pld_pkg::ADR_DIS_LO: rd = s_q.cfg.dis[31:0];
                pld_pkg::ADR_DIS_HI: rd = s_q.cfg.dis[63:32];
                pld_pkg::ADR_PRELOAD: rd = {24'h000000, cell_q};
                pld_pkg::ADR_STATUS: rd = {29'h00000000, mode, s_q.standby};
                default: rd = 32'h00000000;
            endcase
        end
        // Preload skips this merge: cells load wb_dat_i directly, whatever wb_sel_i selects
        w = merge(rd, wb_dat_i, wb_sel_i);
        s_d.ack = req;
        s_d.dat = req ? rd : 32'h00000000;
        if (wr && is_row(wb_adr_i))
            s_d.rows[wb_adr_i[7:2]] = w[29:0];
        else if (wr)
        begin
            case (wb_adr_i)
                pld_pkg::ADR_MODE: s_d.cfg.mode_bits = w[1:0];
                pld_pkg::ADR_POL: s_d.cfg.pol = w[7:0];
                pld_pkg::ADR_IOSEL: s_d.cfg.io_sel = w[7:0];
                pld_pkg::ADR_SIG_LO: s_d.cfg.sig[31:0] = w;
                pld_pkg::ADR_SIG_HI: s_d.cfg.sig[63:32] = w;
                pld_pkg::ADR_DIS_LO: s_d.cfg.dis[31:0] = w;
                pld_pkg::ADR_DIS_HI: s_d.cfg.dis[63:32] = w;
                default: s_d.cfg = s_q.cfg;
            endcase
        end
        s_d.clkp = clk_pin_i;
        s_d.standby = power_down_i;
        s_d.pin_o = cell_drive;
        // Standby floats every cell pin; registers keep their contents
        s_d.pin_oe = power_down_i ? 8'h00 : cell_oe;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.ack <= 1'b0;
            s_q.dat <= 32'h00000000;
            s_q.cfg.mode_bits <= pld_pkg::RST_MODE;
            s_q.cfg.pol <= pld_pkg::RST_POL;
            s_q.cfg.io_sel <= pld_pkg::RST_IOSEL;
            s_q.cfg.sig <= pld_pkg::RST_SIG;
            s_q.cfg.dis <= pld_pkg::RST_DIS;
            s_q.rows <= {pld_pkg::N_TERMS{pld_pkg::RST_ROW}};
            s_q.pin_o <= 8'h00;
            s_q.pin_oe <= 8'h00;
            s_q.clkp <= 1'b0;
            s_q.standby <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;
    assign cell_pin_o = s_q.pin_o;
    assign cell_pin_oe_o = s_q.pin_oe;
    assign standby_o = s_q.standby;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_preload_write;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == pld_pkg::ADR_PRELOAD && wb_sel_i[0];
    endsequence

    sequence s_standby_entry;
        power_down_i ##1 power_down_i;
    endsequence

    a_standby_float: assert property (s_standby_entry |-> cell_pin_oe_o == 8'h00 && standby_o)
        else $error("pins driven during standby");
    a_simple_enabled: assert property (
        // Sampled reset keeps the release edge out: pins are still cleared on the edge after it
        (!rst_i && mode == pld_pkg::MODE_SIMPLE && !power_down_i && s_q.cfg.io_sel == 8'h00)
        |=> cell_pin_oe_o == 8'hFF)
        else $error("simple mode output not always enabled");
    a_inner_outputs: assert property (
        (!rst_i && mode == pld_pkg::MODE_SIMPLE && !power_down_i) |=> cell_pin_oe_o[3] && cell_pin_oe_o[4])
        else $error("inner cell not driving in simple mode");
    a_shared_enable: assert property (
        (!rst_i && mode == pld_pkg::MODE_REGISTERED && !power_down_i && s_q.cfg.io_sel == 8'h00)
        |=> cell_pin_oe_o == {8{~$past(oe_pin_n_i)}})
        else $error("registered outputs ignore enable pin");
    a_complex_term_oe: assert property (
        (!rst_i && mode == pld_pkg::MODE_COMPLEX && !power_down_i) |=> cell_pin_oe_o == $past(pt_oe))
        else $error("complex enable not from product term");
    a_reg_hold: assert property (
        !(tick && mode == pld_pkg::MODE_REGISTERED) && !preload |=> $stable(cell_q))
        else $error("register changed without clock pin edge");
    a_preload_load: assert property (s_preload_write |=> cell_q == $past(wb_dat_i[7:0]))
        else $error("preload value not loaded");
    a_reset_clear: assert property ($past(rst_i) |-> cell_q == pld_pkg::RST_CELL_Q)
        else $error("registers not cleared by reset");
endmodule

/* File: testbench/board_model.sv */
// Board-side model of the eight cell pins.
// Assumes the bench sets what the board drives on pins the design releases.
module board_model (
    // Design side
    input wire logic [7:0] drive_i,
    input wire logic [7:0] drive_en_i,
    // Board side
    input wire logic [7:0] board_val_i,
    output logic [7:0] wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins follow the board, never the last value the design drove
    assign wire_o = (drive_i & drive_en_i) | (board_val_i & ~drive_en_i);
endmodule

/* File: testbench/pld_core_test.sv */
// Self-checking bench for the output cell array and its Wishbone slave.
// Assumes the board model resolves the cell pins; all other pins driven here.
module pld_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat, wb_dat_o;
    logic wb_ack_o, standby_o;
    logic clk_pin = 1'b0, oe_pin_n = 1'b1, pd = 1'b0;
    logic [6:0] in_pins = 7'h00;
    logic [7:0] ext_val = 8'hA5;
    logic [7:0] pin_i, pin_o, pin_oe;
    int err_count = 0;
    int checks = 0;

    always #5 clk_i = ~clk_i;

    pld_core i_pld_core (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .clk_pin_i(clk_pin), .oe_pin_n_i(oe_pin_n), .in_i(in_pins), .power_down_i(pd),
        .cell_pin_i(pin_i), .cell_pin_o(pin_o), .cell_pin_oe_o(pin_oe), .standby_o(standby_o)
    );

    board_model i_board_model (
        .drive_i(pin_o), .drive_en_i(pin_oe), .board_val_i(ext_val), .wire_o(pin_i)
    );

    task report_and_stop;
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle: request held until ack is sampled high, released at that edge
    task wb_cycle(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (wb_ack_o !== 1'b1)
        begin
            err_count++;
            report_and_stop;
        end
    endtask

    task wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        wb_cycle(1'b1, a, d, s);
    endtask

    task rd_chk(input logic [9:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h00000000, 4'hF);
        check(rdat, exp);
    endtask

    // Pin outputs are registered: let the change land before sampling
    task settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Power-down pin is only ever a standby request, never a logic input
    task set_pins(input logic c, input logic oen, input logic p);
        @(posedge clk_i);
        clk_pin <= c;
        oe_pin_n <= oen;
        pd <= p;
    endtask

    task test_reset_regs;
        rd_chk(pld_pkg::ADR_MODE, {30'h0, pld_pkg::RST_MODE});
        rd_chk(pld_pkg::ADR_POL, 32'h00000000);
        rd_chk(pld_pkg::ADR_IOSEL, 32'h00000000);
        rd_chk(pld_pkg::ADR_SIG_LO, 32'h00000000);
        rd_chk(pld_pkg::ADR_DIS_HI, 32'h00000000);
        rd_chk(pld_pkg::ADR_PRELOAD, 32'h00000000);
        rd_chk(pld_pkg::ADR_STATUS, 32'h00000000);
        rd_chk(10'h024, 32'h00000000);
    endtask

    task test_reg_access;
        wr(pld_pkg::ADR_POL, 32'h000000FF, 4'h0);
        rd_chk(pld_pkg::ADR_POL, 32'h00000000);
        wr(pld_pkg::ADR_SIG_HI, 32'hDEADBEEF, 4'h5);
        rd_chk(pld_pkg::ADR_SIG_HI, 32'h00AD00EF);
        wr(pld_pkg::ADR_STATUS, 32'hFFFFFFFF, 4'hF);
        rd_chk(pld_pkg::ADR_STATUS, 32'h00000000);
        wr(10'h024, 32'hFFFFFFFF, 4'hF);
        rd_chk(10'h024, 32'h00000000);
    endtask

    task test_simple;
        settle;
        check(32'(pin_oe), 32'hFF);
        check(32'(pin_o), 32'h00);
        wr(pld_pkg::ADR_POL, 32'h81, 4'h1);
        settle;
        check(32'(pin_o), 32'h81);
        // Empty row makes term 0 of cell 0 true
        wr(10'h100, 32'h00000000, 4'hF);
        settle;
        check(32'(pin_o), 32'h80);
        wr(pld_pkg::ADR_DIS_LO, 32'h1, 4'hF);
        settle;
        check(32'(pin_o), 32'h81);
        wr(pld_pkg::ADR_DIS_LO, 32'h0, 4'hF);
        wr(pld_pkg::ADR_IOSEL, 32'hFF, 4'h1);
        settle;
        check(32'(pin_oe), 32'h18);
        wr(pld_pkg::ADR_IOSEL, 32'h00, 4'h1);
        wr(pld_pkg::ADR_POL, 32'h00, 4'h1);
        // Cell 2 term reads column 1, which is pin 0 in simple mode
        wr(10'h140, 32'h00010000, 4'hF);
        settle;
        check(32'(pin_o), 32'h05);
        wr(10'h140, 32'h3FFFFFFF, 4'hF);
    endtask

    task test_registered;
        // Registers are in use, so registered mode is chosen
        wr(pld_pkg::ADR_MODE, 32'h0, 4'h1);
        set_pins(1'b0, 1'b0, 1'b0);
        settle;
        check(32'(pin_o), 32'h00);
        check(32'(pin_oe), 32'hFF);
        set_pins(1'b1, 1'b0, 1'b0);
        set_pins(1'b0, 1'b0, 1'b0);
        settle;
        check(32'(pin_o), 32'h01);
        wr(pld_pkg::ADR_PRELOAD, 32'h5A, 4'h1);
        rd_chk(pld_pkg::ADR_PRELOAD, 32'h5A);
        settle;
        check(32'(pin_o), 32'h5A);
        set_pins(1'b0, 1'b1, 1'b0);
        settle;
        check(32'(pin_oe), 32'h00);
        set_pins(1'b1, 1'b1, 1'b0);
        set_pins(1'b0, 1'b1, 1'b0);
        rd_chk(pld_pkg::ADR_PRELOAD, 32'h01);
        wr(pld_pkg::ADR_IOSEL, 32'h01, 4'h1);
        settle;
        check(32'(pin_oe), 32'h01);
        check(32'(pin_o[0]), 32'h0);
        wr(pld_pkg::ADR_IOSEL, 32'h00, 4'h1);
        rd_chk(pld_pkg::ADR_STATUS, 32'h6);
    endtask

    task test_complex;
        wr(pld_pkg::ADR_MODE, 32'h3, 4'h1);
        // Enable term of cell 1 follows the clock pin through the outer feedback column
        wr(10'h120, 32'h10000000, 4'hF);
        set_pins(1'b0, 1'b0, 1'b0);
        settle;
        check(32'(pin_oe), 32'h01);
        check(32'(pin_o[0]), 32'h0);
        set_pins(1'b1, 1'b0, 1'b0);
        settle;
        check(32'(pin_oe), 32'h03);
        set_pins(1'b0, 1'b0, 1'b0);
        rd_chk(pld_pkg::ADR_STATUS, 32'h2);
    endtask

    task test_power_down;
        wr(pld_pkg::ADR_MODE, 32'h0, 4'h1);
        wr(pld_pkg::ADR_PRELOAD, 32'hC3, 4'h1);
        set_pins(1'b0, 1'b0, 1'b1);
        settle;
        check(32'(standby_o), 32'h1);
        check(32'(pin_oe), 32'h00);
        set_pins(1'b1, 1'b0, 1'b1);
        set_pins(1'b0, 1'b0, 1'b1);
        rd_chk(pld_pkg::ADR_STATUS, 32'h7);
        set_pins(1'b0, 1'b0, 1'b0);
        settle;
        rd_chk(pld_pkg::ADR_PRELOAD, 32'hC3);
        check(32'(pin_oe), 32'hFF);
    endtask

    // Reset in mid-run must clear loaded registers and return the mode to RST_MODE
    task test_mid_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(pld_pkg::ADR_PRELOAD, 32'h00000000);
        rd_chk(pld_pkg::ADR_MODE, {30'h0, pld_pkg::RST_MODE});
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_regs;
        test_reg_access;
        test_simple;
        test_registered;
        test_complex;
        test_power_down;
        test_mid_reset;
        report_and_stop;
    end
endmodule
